// >>> test/host_master.sv
`timescale 1ns/1ps
// host side: one request at a time, held until waitrequest is seen low
module host_master (
	input wire logic clk,
	output logic [10:0] address,
	output logic read,
	output logic write,
	output logic [31:0] writedata,
	output logic [3:0] byteenable,
	input wire logic [31:0] readdata,
	input wire logic waitrequest
);
	initial
	begin
		address = 11'h000;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h0;
		byteenable = 4'h0;
	end

	// released lines show the inverse so stale values cannot pass
	task automatic wr(input logic [10:0] a, input logic [31:0] d,
		input logic [3:0] be);
		@(posedge clk);
		write <= 1'b1;
		address <= a;
		writedata <= d;
		byteenable <= be;
		// the edge that sees waitrequest low is the one that takes the write
		do @(posedge clk); while (waitrequest);
		write <= 1'b0;
		address <= ~a;
		writedata <= ~d;
	endtask : wr

	task automatic rd(input logic [10:0] a, output logic [31:0] d);
		@(posedge clk);
		read <= 1'b1;
		address <= a;
		byteenable <= 4'hf;
		// read data is taken at the same edge that sees waitrequest low
		do @(posedge clk); while (waitrequest);
		d = readdata;
		read <= 1'b0;
		address <= ~a;
	endtask : rd
endmodule : host_master

// >>> test/selftest_log_and_health_errors_tb.sv
`timescale 1ns/1ps
`define CHK(got, exp) \
	begin \
		compares++; \
		if ((got) !== (exp)) \
		begin \
			failures++; \
			$display("wrong value at %0t: %h not %h", $time, got, exp); \
		end \
	end

module selftest_log_and_health_errors_tb;
	logic clk;
	logic rst;
	logic [10:0] address;
	logic read;
	logic write;
	logic [31:0] writedata;
	logic [3:0] byteenable;
	logic [31:0] readdata;
	logic waitrequest;
	logic irq;
	int failures;
	int compares;
	logic [31:0] d;
	logic [7:0] sum;
	logic [10:0] base;
	logic [4:0] p;

	selftest_log_core u_dut (.clk(clk), .rst(rst), .address(address),
		.read(read), .write(write), .writedata(writedata),
		.byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .irq(irq));
	host_master u_host (.clk(clk), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest));

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic close_out;
		$display("failures %0d compares %0d", failures, compares);
		if (failures == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : close_out

	// taskfile then opcode, answer read back as error:status
	task automatic cmd(input logic [31:0] tf, input logic [7:0] op,
		input logic [15:0] exp);
		u_host.wr(11'h41c, tf, 4'hf);
		u_host.wr(11'h420, {24'h0, op}, 4'hf);
		u_host.rd(11'h420, d);
		`CHK(d[15:0], exp)
	endtask : cmd

	// sum of all 512 log bytes must come to zero
	task automatic sector_sum;
		sum = 8'h00;
		for (int w = 0; w < 128; w++)
		begin
			u_host.rd(11'(w * 4), d);
			sum = sum + d[7:0] + d[15:8] + d[23:16] + d[31:24];
		end
		`CHK(sum, 8'h00)
	endtask : sector_sum

	task automatic commit(input int i);
		u_host.wr(11'h400, {16'h1200 | 16'(i), 8'h70, 8'(i)}, 4'hf);
		u_host.wr(11'h404, 32'(i), 4'hf);
		u_host.wr(11'h408, 32'ha0b0c000 | 32'(i), 4'hf);
		u_host.wr(11'h40c, 32'h1, 4'hf);
		do u_host.rd(11'h40c, d); while (d[0] !== 1'b0);
		p = 5'((i - 1) % 21 + 1);
		`CHK(d[12:8], p)
		base = 11'((p - 1) * 24);
		u_host.rd(base, d);
		`CHK(d[31:16], {8'h70, 8'(i)})
		u_host.rd(base + 11'd4, d);
		`CHK(d, {8'(i), 8'(i), 16'h1200 | 16'(i)})
		u_host.rd(base + 11'd8, d);
		`CHK(d[23:0], 24'ha0b0c0)
	endtask : commit

	initial
	begin
		repeat (60000) @(posedge clk);
		failures++;
		close_out;
	end

	initial
	begin
		rst = 1'b1;
		failures = 0;
		compares = 0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		u_host.rd(11'h1fc, d);
		`CHK(d, 32'hff000000)
		sector_sum;
		// first result stays masked, then the mask lets it through
		commit(1);
		@(negedge clk);
		`CHK(irq, 1'b0)
		u_host.wr(11'h42c, 32'h1, 4'hf);
		@(negedge clk);
		`CHK(irq, 1'b1)
		u_host.wr(11'h428, 32'h1, 4'hf);
		@(negedge clk);
		`CHK(irq, 1'b0)
		u_host.wr(11'h42c, 32'h0, 4'hf);
		for (int i = 2; i <= 22; i++)
			commit(i);
		u_host.rd(11'h1fc, d);
		`CHK(d[7:0], 8'h01)
		sector_sum;
		// span pairs written and read back, the tail word half reserved
		for (int w = 0; w < 21; w++)
			u_host.wr(11'h200 + 11'(w * 4), 32'h5a5a0000 | 32'(w), 4'hf);
		for (int w = 0; w < 21; w++)
		begin
			u_host.rd(11'h200 + 11'(w * 4), d);
			`CHK(d, w == 20 ? 32'h00000014 : 32'h5a5a0000 | 32'(w))
		end
		u_host.wr(11'h254, 32'hffffffff, 4'hf);
		u_host.rd(11'h254, d);
		`CHK(d, 32'h0)
		u_host.wr(11'h410, 32'h01234567, 4'hf);
		u_host.wr(11'h414, 32'h89abcdef, 4'hf);
		u_host.wr(11'h418, 32'h3, 4'hf);
		u_host.wr(11'h3ec, 32'h0, 4'hf);
		u_host.wr(11'h3f4, 32'hffffffff, 4'hf);
		u_host.wr(11'h3fc, 32'hffffffff, 4'hf);
		u_host.rd(11'h3ec, d);
		`CHK(d, 32'h01234567)
		u_host.rd(11'h3f0, d);
		`CHK(d, 32'h89abcdef)
		u_host.rd(11'h3f4, d);
		`CHK(d, 32'hffff0003)
		u_host.rd(11'h3fc, d);
		`CHK(d, 32'hff00ffff)
		cmd(32'hc24f00d8, 8'hb0, 16'h0050);
		cmd(32'hc25000d0, 8'hb0, 16'h0451);
		u_host.rd(11'h428, d);
		`CHK(d[2], 1'b1)
		cmd(32'hc24f00d7, 8'hb0, 16'h0451);
		cmd(32'hc24f00d9, 8'hb0, 16'h0050);
		cmd(32'hc24f00d0, 8'hb0, 16'h0451);
		cmd(32'hc24f00d8, 8'hb0, 16'h0050);
		cmd(32'h00000000, 8'h55, 16'h0451);
		u_host.wr(11'h424, 32'h00010000, 4'hf);
		cmd(32'hc24f00d1, 8'hb0, 16'h1051);
		u_host.wr(11'h424, 32'h00030000, 4'hf);
		cmd(32'hc24f00d5, 8'hb0, 16'h4051);
		u_host.wr(11'h424, 32'h00040000, 4'hf);
		cmd(32'hc24f00d2, 8'hb0, 16'h1051);
		u_host.wr(11'h424, 32'h000c0000, 4'hf);
		cmd(32'hc24f00d6, 8'hb0, 16'h0151);
		u_host.wr(11'h424, 32'h0, 4'hf);
		cmd(32'hc24f00d3, 8'hb0, 16'h0050);
		cmd(32'h00000000, 8'he2, 16'h0050);
		u_host.rd(11'h424, d);
		`CHK(d[15:0], 16'h0001)
		cmd(32'h00000500, 8'h96, 16'h0050);
		u_host.rd(11'h424, d);
		`CHK(d[15:0], 16'h0503)
		u_host.rd(11'h600, d);
		`CHK(d, 32'h0)
		close_out;
	end
endmodule : selftest_log_and_health_errors_tb

// >>> test/selftest_log_core_assertions.sv
`timescale 1ns/1ps
// watches the host bus; read data is judged at the edge it is taken
module selftest_log_core_assertions #(
	parameter logic [15:0] REVISION = 16'h0001
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [10:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	input wire logic irq
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// a read of one word completes at this edge
	sequence s_taken(a);
		read && !waitrequest && address == a;
	endsequence

	property p_revision;
		s_taken(11'h000) |-> readdata[15:0] == REVISION;
	endproperty
	a_revision: assert property (p_revision)
		else $error("log revision word wrong");

	property p_pointer;
		s_taken(11'h40c) |-> readdata[12:8] <= 5'd21;
	endproperty
	a_pointer: assert property (p_pointer)
		else $error("log pointer out of range");

	// an abort always carries one of the documented error codes
	property p_abort_code;
		s_taken(11'h420) ##0 readdata[7:0] == 8'h51
			|-> readdata[15:8] inside {8'h04, 8'h10, 8'h40, 8'h01};
	endproperty
	a_abort_code: assert property (p_abort_code)
		else $error("abort with unknown error code");

	property p_ok_code;
		s_taken(11'h420) ##0 readdata[7:0] == 8'h50 |-> readdata[15:8] == 8'h00;
	endproperty
	a_ok_code: assert property (p_ok_code)
		else $error("good status with error bits");

	property p_sel_reserved;
		read && !waitrequest && address inside {[11'h254:11'h34c]}
			|-> readdata == 32'h0;
	endproperty
	a_sel_reserved: assert property (p_sel_reserved)
		else $error("reserved selective bytes not zero");

	property p_unmapped;
		read && !waitrequest && address[10:9] == 2'd3 |-> readdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");

	property p_read_wait;
		$rose(read) |-> waitrequest;
	endproperty
	a_read_wait: assert property (p_read_wait)
		else $error("read answered in its first cycle");

	property p_hold;
		!read |=> $stable(readdata);
	endproperty
	a_hold: assert property (p_hold)
		else $error("read data moved without a read");

	property p_reset;
		@(posedge clk) disable iff (1'b0) rst |=> readdata == 32'h0 && !irq;
	endproperty
	a_reset: assert property (p_reset)
		else $error("outputs not quiet after reset");
endmodule : selftest_log_core_assertions

bind selftest_log_core selftest_log_core_assertions #(.REVISION(REVISION)) u_chk (
	.clk(clk),
	.rst(rst),
	.address(address),
	.read(read),
	.write(write),
	.writedata(writedata),
	.byteenable(byteenable),
	.readdata(readdata),
	.waitrequest(waitrequest),
	.irq(irq)
);

// >>> verilog/log_checksum.sv
`timescale 1ns/1ps
`include "selftest_params.svh"

// walks the first BYTES-1 bytes of a sector and returns their negated sum
module log_checksum #(
	parameter int BYTES = `SECTOR_BYTES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	input wire logic [7:0] byte_in,
	output logic [$clog2(BYTES)-1:0] byte_addr,
	output logic busy,
	output logic done,
	output logic [7:0] csum
);
	localparam int AW = $clog2(BYTES);
	localparam logic [AW-1:0] LAST = AW'(BYTES - 2);

	logic [7:0] acc, next_acc, next_csum;
	logic [AW-1:0] next_addr;
	logic next_busy, next_done;

	// one byte per cycle; the sum byte itself is never read
	always_comb
	begin
		next_acc = acc;
		next_addr = byte_addr;
		next_busy = busy;
		next_done = 1'b0;
		next_csum = csum;
		if (start && !busy)
		begin
			next_busy = 1'b1;
			next_addr = '0;
			next_acc = 8'h00;
		end
		else if (busy)
		begin
			next_acc = 8'(acc + byte_in);
			next_addr = AW'(byte_addr + 1'b1);
			if (byte_addr == LAST)
			begin
				next_busy = 1'b0;
				next_done = 1'b1;
				next_csum = 8'(8'h00 - next_acc);
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			acc <= 8'h00;
			byte_addr <= '0;
			busy <= 1'b0;
			done <= 1'b0;
			csum <= 8'h00;
		end
		else
		begin
			acc <= next_acc;
			byte_addr <= next_addr;
			busy <= next_busy;
			done <= next_done;
			csum <= next_csum;
		end
	end

endmodule : log_checksum

// >>> verilog/selftest_log_core.sv
`timescale 1ns/1ps
`include "selftest_params.svh"

module selftest_log_core #(
	parameter logic [7:0] KEY_MID = 8'h4f,
	parameter logic [7:0] KEY_HIGH = 8'hc2,
	parameter logic [15:0] REVISION = `LOG_REVISION
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [10:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	output logic irq
);
	import selftest_pkg::*;

	logic [7:0] log_mem [0:`SECTOR_BYTES-1];
	logic [7:0] sel_mem [0:`SECTOR_BYTES-1];

	state_type state, next_state;
	logic [8:0] cnt, next_cnt;
	logic [4:0] ptr, next_ptr;
	result_type result, next_result;
	logic [63:0] prog_lba, next_prog_lba;
	logic [15:0] prog_span, next_prog_span;
	taskfile_type tf, next_tf;
	answer_type answer, next_answer;
	logic enabled, next_enabled;
	logic auto_pd, next_auto_pd;
	logic [7:0] pd_timer, next_pd_timer;
	logic [3:0] fault, next_fault;
	logic [2:0] irq_stat, next_irq_stat, irq_mask, next_irq_mask;
	logic [31:0] next_readdata;
	logic rd_ready, next_rd_ready;

	logic lw_en;
	logic [8:0] lw_addr;
	logic [7:0] lw_data;
	logic [8:0] walk_addr;
	logic sum_start, sum_busy, sum_done;
	logic [7:0] sum_val;

	logic [1:0] win;
	logic [8:0] off;
	logic stall, wr_go, log_done, cmd_ok, cmd_abort;

	// descriptor start for a pointer value 1..21
	function automatic logic [8:0] desc_base(input logic [4:0] p);
		desc_base = 9'(({4'h0, p} - 9'd1) * `DESC_BYTES + `DESC_BASE);
	endfunction : desc_base

	// byte i of a descriptor, low byte first, vendor bytes zero
	function automatic logic [7:0] desc_byte(input result_type r,
		input logic [4:0] i);
		case (i)
			5'd0: desc_byte = r.test_num;
			5'd1: desc_byte = r.exec_status;
			5'd2: desc_byte = r.hours[7:0];
			5'd3: desc_byte = r.hours[15:8];
			5'd4: desc_byte = r.checkpoint;
			5'd5: desc_byte = r.fail_lba[7:0];
			5'd6: desc_byte = r.fail_lba[15:8];
			5'd7: desc_byte = r.fail_lba[23:16];
			5'd8: desc_byte = r.fail_lba[31:24];
			default: desc_byte = 8'h00;
		endcase
	endfunction : desc_byte

	// host may only store into its own selective-log fields
	function automatic logic sel_rw(input logic [8:0] a);
		sel_rw = (a < `SEL_SPAN_END)
			|| (a[8:1] == `SEL_FLAGS >> 1)
			|| (a[8:1] == `SEL_PENDING >> 1) || (a == `CSUM_OFS);
	endfunction : sel_rw

	function automatic logic known_sub(input logic [7:0] f);
		case (f)
			`SUB_READ_DATA, `SUB_READ_THRESH, `SUB_AUTOSAVE, `SUB_SAVE,
			`SUB_OFFLINE, `SUB_READ_LOG, `SUB_WRITE_LOG, `SUB_ENABLE,
			`SUB_DISABLE, `SUB_STATUS: known_sub = 1'b1;
			default: known_sub = 1'b0;
		endcase
	endfunction : known_sub

	log_checksum #(.BYTES(`SECTOR_BYTES)) u_sum (
		.clk(clk),
		.rst(rst),
		.start(sum_start),
		.byte_in(log_mem[walk_addr]),
		.byte_addr(walk_addr),
		.busy(sum_busy),
		.done(sum_done),
		.csum(sum_val)
	);

	// decode; log reads wait while the sector is being rewritten
	assign win = address[10:9];
	assign off = address[8:0];
	assign stall = (state == S_CLEAR)
		|| (win == `WIN_LOG && state != S_IDLE)
		|| (write && win == `WIN_REG && off == `REG_LOG_CMD
			&& state != S_IDLE);
	assign waitrequest = (read && !rd_ready) || ((read || write) && stall);
	assign wr_go = write && !stall;
	assign irq = |(irq_stat & irq_mask);

	// log engine: clear after reset, then descriptor, pointer, checksum
	always_comb
	begin
		next_state = state;
		next_cnt = cnt;
		next_ptr = ptr;
		lw_en = 1'b0;
		lw_addr = cnt;
		lw_data = 8'h00;
		sum_start = 1'b0;
		log_done = 1'b0;
		unique case (state)
			S_CLEAR:
			begin
				lw_en = 1'b1;
				if (cnt == 9'd0)
					lw_data = REVISION[7:0];
				else if (cnt == 9'd1)
					lw_data = REVISION[15:8];
				next_cnt = 9'(cnt + 1'b1);
				if (cnt == `CSUM_OFS)
				begin
					next_state = S_SUM;
					sum_start = 1'b1;
				end
			end
			S_IDLE:
			begin
				if (wr_go && win == `WIN_REG && off == `REG_LOG_CMD
					&& byteenable[0] && writedata[0])
				begin
					next_ptr = (ptr == `LOG_SLOTS) ? 5'd1 : 5'(ptr + 1'b1);
					next_cnt = 9'd0;
					next_state = S_DESC;
				end
			end
			S_DESC:
			begin
				lw_en = 1'b1;
				lw_addr = 9'(desc_base(ptr) + cnt);
				lw_data = desc_byte(result, cnt[4:0]);
				next_cnt = 9'(cnt + 1'b1);
				if (cnt[4:0] == `DESC_LAST)
					next_state = S_SUM;
				sum_start = (cnt[4:0] == `DESC_LAST);
			end
			S_SUM:
			begin
				if (sum_done)
				begin
					lw_en = 1'b1;
					lw_addr = `CSUM_OFS;
					lw_data = sum_val;
					next_state = S_IDLE;
					log_done = 1'b1;
				end
			end
		endcase
		// pointer byte is written before the walk reaches it
		if (state == S_DESC && cnt[4:0] == `DESC_LAST)
		begin
			lw_addr = `PTR_OFS;
			lw_data = {3'b000, ptr};
		end
	end

	// descriptor write order: bytes 0..22, then byte 23 written as zero in the same cycle as the pointer
	always_ff @(posedge clk)
	begin
		if (lw_en)
			log_mem[lw_addr] <= lw_data;
		if (state == S_DESC && cnt[4:0] == `DESC_LAST)
			log_mem[9'(desc_base(ptr) + cnt)] <= 8'h00;
	end

	// selective log storage, cleared with the log after reset
	always_ff @(posedge clk)
	begin
		if (state == S_CLEAR)
			sel_mem[cnt] <= 8'h00;
		else if (wr_go && win == `WIN_SEL)
			for (int i = 0; i < 4; i++)
				if (byteenable[i] && sel_rw(9'(off + i)))
					sel_mem[9'(off + i)] <= writedata[8*i +: 8];
	end

	// command evaluation and software registers
	always_comb
	begin
		next_result = result;
		next_prog_lba = prog_lba;
		next_prog_span = prog_span;
		next_tf = tf;
		next_answer = answer;
		next_enabled = enabled;
		next_auto_pd = auto_pd;
		next_pd_timer = pd_timer;
		next_fault = fault;
		next_irq_mask = irq_mask;
		cmd_ok = 1'b0;
		cmd_abort = 1'b0;
		if (wr_go && win == `WIN_REG)
		begin
			case (off)
				`REG_RESULT0:
				begin
					// field by field: the packed order differs from the word
					next_result.test_num = writedata[7:0];
					next_result.exec_status = writedata[15:8];
					next_result.hours = writedata[31:16];
				end
				`REG_RESULT1: next_result.checkpoint = writedata[7:0];
				`REG_RESULT_LBA: next_result.fail_lba = writedata;
				`REG_PROG_LO: next_prog_lba[31:0] = writedata;
				`REG_PROG_HI: next_prog_lba[63:32] = writedata;
				`REG_PROG_SPAN: next_prog_span = writedata[15:0];
				`REG_TASKFILE: next_tf = writedata;
				`REG_HEALTH: next_fault = writedata[19:16];
				`REG_IRQ_MASK: next_irq_mask = writedata[2:0];
				`REG_COMMAND:
				begin
					next_answer = '{error: `ERR_NONE, status: `ST_OK};
					if (writedata[7:0] == `CMD_STANDBY
						|| writedata[7:0] == `CMD_STANDBY_ALT)
					begin
						next_auto_pd = (tf.sector_count != 8'h00);
						next_pd_timer = tf.sector_count;
					end
					else if (writedata[7:0] != `CMD_HEALTH)
						next_answer.error = `ERR_ABRT;
					else if (tf.lba_mid != KEY_MID || tf.lba_high != KEY_HIGH)
						next_answer.error = `ERR_ABRT;
					else if (!known_sub(tf.features))
						next_answer.error = `ERR_ABRT;
					else if (!enabled && tf.features != `SUB_ENABLE)
						next_answer.error = `ERR_ABRT;
					else
						case (tf.features)
							`SUB_ENABLE: next_enabled = 1'b1;
							`SUB_DISABLE: next_enabled = 1'b0;
							`SUB_READ_DATA, `SUB_READ_THRESH, `SUB_READ_LOG:
								if (fault[1])
									next_answer.error = `ERR_UNC;
								else if (fault[0])
									next_answer.error = `ERR_IDNF;
							`SUB_SAVE, `SUB_AUTOSAVE, `SUB_WRITE_LOG:
								if (fault[3])
									next_answer.error = `ERR_AMNF;
								else if (fault[2])
									next_answer.error = `ERR_IDNF;
							default: next_answer.error = `ERR_NONE;
						endcase
					if (next_answer.error != `ERR_NONE)
						next_answer.status = `ST_ABORT;
					cmd_abort = (next_answer.error != `ERR_NONE);
					cmd_ok = !cmd_abort;
				end
				default: next_answer = answer;
			endcase
		end
		// a new event beats a simultaneous clear
		next_irq_stat = irq_stat;
		if (wr_go && win == `WIN_REG && off == `REG_IRQ_STATUS)
			next_irq_stat = irq_stat & ~writedata[2:0];
		next_irq_stat = next_irq_stat | {cmd_abort, cmd_ok, log_done};
	end

	// registered read data, at least one wait cycle per read, more while stall holds it
	always_comb
	begin
		next_rd_ready = read && !rd_ready && !stall;
		next_readdata = readdata;
		if (next_rd_ready)
		begin
			next_readdata = 32'h0000_0000;
			case (win)
				`WIN_LOG: next_readdata = {log_mem[9'(off + 3)],
					log_mem[9'(off + 2)], log_mem[9'(off + 1)], log_mem[off]};
				`WIN_SEL:
					if (off >= `SEL_CUR_LBA && off < `SEL_FLAGS)
					begin
						// progress fields come from device state
						if (off == `SEL_CUR_LBA)
							next_readdata = prog_lba[31:0];
						else if (off == 9'(`SEL_CUR_LBA + 3'd4))
							next_readdata = prog_lba[63:32];
						else
							// span from device state, flags from host bytes
							next_readdata = {sel_mem[9'(off + 3)],
								sel_mem[9'(off + 2)], prog_span};
					end
					else
						next_readdata = {sel_mem[9'(off + 3)],
							sel_mem[9'(off + 2)], sel_mem[9'(off + 1)],
							sel_mem[off]};
				`WIN_REG:
					case (off)
						`REG_RESULT0: next_readdata = {result.hours,
							result.exec_status, result.test_num};
						`REG_RESULT1: next_readdata = {24'h0, result.checkpoint};
						`REG_RESULT_LBA: next_readdata = result.fail_lba;
						`REG_LOG_CMD: next_readdata = {19'h0, ptr,
							7'h0, (state != S_IDLE)};
						`REG_PROG_LO: next_readdata = prog_lba[31:0];
						`REG_PROG_HI: next_readdata = prog_lba[63:32];
						`REG_PROG_SPAN: next_readdata = {16'h0, prog_span};
						`REG_TASKFILE: next_readdata = tf;
						`REG_COMMAND: next_readdata = {16'h0, answer};
						`REG_HEALTH: next_readdata = {12'h0, fault, pd_timer,
							6'h0, auto_pd, enabled};
						`REG_IRQ_STATUS: next_readdata = {29'h0, irq_stat};
						`REG_IRQ_MASK: next_readdata = {29'h0, irq_mask};
						default: next_readdata = 32'h0000_0000;
					endcase
				default: next_readdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state <= S_CLEAR;
			cnt <= 9'd0;
			ptr <= 5'd0;
			result <= '0;
			prog_lba <= 64'h0;
			prog_span <= 16'h0;
			tf <= '0;
			answer <= '{error: `ERR_NONE, status: `ST_OK};
			enabled <= 1'b0;
			auto_pd <= 1'b0;
			pd_timer <= 8'h00;
			fault <= 4'h0;
			irq_stat <= 3'b000;
			irq_mask <= 3'b000;
			readdata <= 32'h0000_0000;
			rd_ready <= 1'b0;
		end
		else
		begin
			state <= next_state;
			cnt <= next_cnt;
			ptr <= next_ptr;
			result <= next_result;
			prog_lba <= next_prog_lba;
			prog_span <= next_prog_span;
			tf <= next_tf;
			answer <= next_answer;
			enabled <= next_enabled;
			auto_pd <= next_auto_pd;
			pd_timer <= next_pd_timer;
			fault <= next_fault;
			irq_stat <= next_irq_stat;
			irq_mask <= next_irq_mask;
			readdata <= next_readdata;
			rd_ready <= next_rd_ready;
		end
	end

endmodule : selftest_log_core

// >>> verilog/selftest_params.svh
`ifndef SELFTEST_PARAMS_SVH
`define SELFTEST_PARAMS_SVH

// sector geometry
`define SECTOR_BYTES 512
`define LOG_SLOTS 5'd21
`define DESC_BYTES 9'd24
`define DESC_BASE 9'd2
`define DESC_LAST 5'd23
`define PTR_OFS 9'h1fc
`define CSUM_OFS 9'h1ff
`define LOG_REVISION 16'h0001

// selective log field offsets
`define SEL_SPAN_END 9'h052
`define SEL_CUR_LBA 9'h1ec
`define SEL_CUR_SPAN 9'h1f4
`define SEL_FLAGS 9'h1f6
`define SEL_PENDING 9'h1fc

// bus map (byte addresses)
`define WIN_LOG 2'd0
`define WIN_SEL 2'd1
`define WIN_REG 2'd2
`define REG_RESULT0 9'h000
`define REG_RESULT1 9'h004
`define REG_RESULT_LBA 9'h008
`define REG_LOG_CMD 9'h00c
`define REG_PROG_LO 9'h010
`define REG_PROG_HI 9'h014
`define REG_PROG_SPAN 9'h018
`define REG_TASKFILE 9'h01c
`define REG_COMMAND 9'h020
`define REG_HEALTH 9'h024
`define REG_IRQ_STATUS 9'h028
`define REG_IRQ_MASK 9'h02c

// command opcodes and subcommands
`define CMD_HEALTH 8'hb0
`define CMD_STANDBY 8'he2
`define CMD_STANDBY_ALT 8'h96
`define SUB_READ_DATA 8'hd0
`define SUB_READ_THRESH 8'hd1
`define SUB_AUTOSAVE 8'hd2
`define SUB_SAVE 8'hd3
`define SUB_OFFLINE 8'hd4
`define SUB_READ_LOG 8'hd5
`define SUB_WRITE_LOG 8'hd6
`define SUB_ENABLE 8'hd8
`define SUB_DISABLE 8'hd9
`define SUB_STATUS 8'hda

// answers
`define ST_OK 8'h50
`define ST_ABORT 8'h51
`define ERR_NONE 8'h00
`define ERR_ABRT 8'h04
`define ERR_IDNF 8'h10
`define ERR_UNC 8'h40
`define ERR_AMNF 8'h01

`endif

// >>> verilog/selftest_pkg.sv
package selftest_pkg;

	// log engine states, one-hot
	typedef enum logic [3:0] {
		S_CLEAR = 4'b0001,
		S_IDLE = 4'b0010,
		S_DESC = 4'b0100,
		S_SUM = 4'b1000
	} state_type;

	// one finished self-test as firmware posts it
	typedef struct packed {
		logic [7:0] test_num;
		logic [7:0] exec_status;
		logic [15:0] hours;
		logic [7:0] checkpoint;
		logic [31:0] fail_lba;
	} result_type;

	// command block inputs
	typedef struct packed {
		logic [7:0] lba_high;
		logic [7:0] lba_mid;
		logic [7:0] sector_count;
		logic [7:0] features;
	} taskfile_type;

	// status and error pair returned to the host
	typedef struct packed {
		logic [7:0] error;
		logic [7:0] status;
	} answer_type;

endpackage : selftest_pkg
